// >>> src/ccev_pkg.sv
// condition code evaluator: shared constants, types and decode functions
// assumes: flags come from execute logic on the same clock as the evaluator

package ccev_pkg;

	// ****************************************
	// widths and flag positions
	// ****************************************
	localparam int unsigned SUBCODE_W  = 4;
	localparam int unsigned BASE_N     = 8;
	localparam int unsigned BASE_IDX_W = 3;
	localparam int unsigned BYTE_W     = 8;
	localparam int unsigned POL_BIT    = 0;
	localparam int unsigned IDX_LSB    = 1;

	// ****************************************
	// subcodes
	// ****************************************
	localparam logic [3:0] SC_OVERFLOW    = 4'h0;
	localparam logic [3:0] SC_NO_OVERFLOW = 4'h1;
	localparam logic [3:0] SC_BELOW       = 4'h2;
	localparam logic [3:0] SC_ABOVE_EQ    = 4'h3;
	localparam logic [3:0] SC_EQUAL       = 4'h4;
	localparam logic [3:0] SC_NOT_EQUAL   = 4'h5;
	localparam logic [3:0] SC_BELOW_EQ    = 4'h6;
	localparam logic [3:0] SC_ABOVE       = 4'h7;
	localparam logic [3:0] SC_SIGN        = 4'h8;
	localparam logic [3:0] SC_NO_SIGN     = 4'h9;
	localparam logic [3:0] SC_PARITY      = 4'hA;
	localparam logic [3:0] SC_NO_PARITY   = 4'hB;
	localparam logic [3:0] SC_LESS        = 4'hC;
	localparam logic [3:0] SC_GREATER_EQ  = 4'hD;
	localparam logic [3:0] SC_LESS_EQ     = 4'hE;
	localparam logic [3:0] SC_GREATER     = 4'hF;

	// ****************************************
	// base test slots, one per subcode pair
	// ****************************************
	localparam logic [2:0] BT_OVERFLOW = 3'h0;
	localparam logic [2:0] BT_CARRY    = 3'h1;
	localparam logic [2:0] BT_ZERO     = 3'h2;
	localparam logic [2:0] BT_CARRY_ZR = 3'h3;
	localparam logic [2:0] BT_SIGN     = 3'h4;
	localparam logic [2:0] BT_PARITY   = 3'h5;
	localparam logic [2:0] BT_LESS     = 3'h6;
	localparam logic [2:0] BT_LESS_EQ  = 3'h7;

	localparam logic [7:0] SET_TRUE  = 8'h01;
	localparam logic [7:0] SET_FALSE = 8'h00;

	// ****************************************
	// instruction families
	// ****************************************
	typedef enum logic [1:0] {
		FAM_MOVE  = 2'b00,
		FAM_FMOVE = 2'b01,
		FAM_JUMP  = 2'b10,
		FAM_SET   = 2'b11
	} ccev_family_t;

	// ****************************************
	// decode functions
	// ****************************************
	function automatic logic [2:0] ccev_pair_idx(input logic [3:0] sc);
		ccev_pair_idx = sc[SUBCODE_W-1:IDX_LSB];
	endfunction : ccev_pair_idx

	function automatic logic ccev_negated(input logic [3:0] sc);
		ccev_negated = sc[POL_BIT];
	endfunction : ccev_negated

endpackage : ccev_pkg

// >>> src/ccev_flags_if.sv
// condition code evaluator: flag carrier between top and base test unit
// assumes: both ends sit in the same clock domain, no storage inside

`timescale 1ns/1ps

interface ccev_flags_if;
	import ccev_pkg::*;

	logic             carry_flag;
	logic             overflow_flag;
	logic             sign_flag;
	logic             zero_flag;
	logic             parity_flag;
	logic [BASE_N-1:0] base_tests;

	modport src (
		output carry_flag,
		output overflow_flag,
		output sign_flag,
		output zero_flag,
		output parity_flag,
		input  base_tests
	);

	modport eval (
		input  carry_flag,
		input  overflow_flag,
		input  sign_flag,
		input  zero_flag,
		input  parity_flag,
		output base_tests
	);
endinterface : ccev_flags_if

// >>> src/ccev_base_tests.sv
// condition code evaluator: eight positive base tests from the five flags
// assumes: flags are stable within the cycle; pure gates, no state

`timescale 1ns/1ps

module ccev_base_tests
	import ccev_pkg::*;
(
	// flags in, tests out
	ccev_flags_if.eval fl
);

	// ****************************************
	// shared terms
	// ****************************************
	wire signed_lt;
	wire unsigned_le;

	// unsigned ordering lives on carry and zero
	assign unsigned_le = fl.carry_flag | fl.zero_flag;
	// signed ordering lives on sign and overflow
	assign signed_lt = fl.sign_flag ^ fl.overflow_flag;

	// ****************************************
	// slots
	// ****************************************
	assign fl.base_tests[BT_OVERFLOW] = fl.overflow_flag;
	assign fl.base_tests[BT_CARRY]    = fl.carry_flag;
	assign fl.base_tests[BT_ZERO]     = fl.zero_flag;
	assign fl.base_tests[BT_CARRY_ZR] = unsigned_le;
	assign fl.base_tests[BT_SIGN]     = fl.sign_flag;
	assign fl.base_tests[BT_PARITY]   = fl.parity_flag;
	assign fl.base_tests[BT_LESS]     = signed_lt;
	assign fl.base_tests[BT_LESS_EQ]  = signed_lt | fl.zero_flag;

endmodule : ccev_base_tests

// >>> src/ccev_top.sv
// condition code evaluator: subcode decode, polarity, per-family results
// assumes: subcode, flags and family come from decode/execute on core_clk_i

`timescale 1ns/1ps

// Operation
// - test is chosen by a four-bit subcode ranging 0000 to 1111.
// - overflow, zero, sign, parity tested set on even, clear on odd code.
// - below is carry set, above-or-equal is carry clear.
// - below-or-equal is carry or zero set, above is both clear.
// - less is sign xor overflow set, greater-or-equal is it clear.
// - less-or-equal adds zero to less; greater is that term clear.
// - above and below are unsigned orderings built from carry.
// - greater and less are signed orderings built from sign and overflow.
// - alias condition names share one subcode and one evaluation.
// - one encoding serves move, float move, jump and set-byte.
module ccev_top
	import ccev_pkg::*;
(
	// clock and reset
	input  wire logic              core_clk_i,
	input  wire logic              rst_i,
	// request
	input  wire logic              valid_i,
	input  wire logic [1:0]        family_i,
	input  wire logic [3:0]        subcode_i,
	// status flags
	input  wire logic              carry_flag_i,
	input  wire logic              overflow_flag_i,
	input  wire logic              sign_flag_i,
	input  wire logic              zero_flag_i,
	input  wire logic              parity_flag_i,
	// same-cycle answers
	output logic                   cond_true_o,
	output logic                   move_en_o,
	output logic                   jump_taken_o,
	// registered answers
	output logic                   cond_ff_o,
	output logic                   result_valid_o,
	output logic [7:0]             set_byte_o
);

	// ****************************************
	// flag carrier and base tests
	// ****************************************
	ccev_flags_if fl ();

	assign fl.carry_flag    = carry_flag_i;
	assign fl.overflow_flag = overflow_flag_i;
	assign fl.sign_flag     = sign_flag_i;
	assign fl.zero_flag     = zero_flag_i;
	assign fl.parity_flag   = parity_flag_i;

	ccev_base_tests u_base (
		.fl (fl.eval)
	);

	// ****************************************
	// subcode decode
	// ****************************************
	wire logic [2:0]   pair_idx;
	wire logic         negated;
	wire logic         base_hit;
	wire logic         cond_true;
	wire ccev_family_t family;
	wire logic         is_move;
	wire logic         is_jump;
	wire logic         is_set;

	// every 4-bit value is a legal test, nothing left undecoded
	assign pair_idx  = ccev_pair_idx(subcode_i);
	assign negated   = ccev_negated(subcode_i);
	// aliases are only names; the hardware sees one subcode
	assign base_hit  = fl.base_tests[pair_idx];
	assign cond_true = base_hit ^ negated;

	// ****************************************
	// family steering
	// ****************************************
	// family only routes the result, never alters the test
	assign family  = ccev_family_t'(family_i);
	assign is_move = (family == FAM_MOVE) | (family == FAM_FMOVE);
	assign is_jump = (family == FAM_JUMP);
	assign is_set  = (family == FAM_SET);

	// no flop in the path: decode needs the answer this cycle
	assign cond_true_o  = cond_true;
	assign move_en_o    = valid_i & is_move & cond_true;
	assign jump_taken_o = valid_i & is_jump & cond_true;

	// ****************************************
	// registered copy for write-back
	// ****************************************
	logic       cond_ff;
	logic       result_valid_ff;
	logic [7:0] set_byte_ff;
	logic [7:0] nxt_set_byte;

	assign nxt_set_byte = cond_true ? SET_TRUE : SET_FALSE;

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			cond_ff         <= 1'b0;
			result_valid_ff <= 1'b0;
			set_byte_ff     <= SET_FALSE;
		end else begin
			cond_ff         <= cond_true;
			result_valid_ff <= valid_i;
			if (valid_i && is_set) begin
				set_byte_ff <= nxt_set_byte;
			end
		end
	end

	assign cond_ff_o      = cond_ff;
	assign result_valid_o = result_valid_ff;
	assign set_byte_o     = set_byte_ff;

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (rst_i);

	wire logic ref_lt;
	wire logic ref_le;
	assign ref_lt = sign_flag_i ^ overflow_flag_i;
	assign ref_le = ref_lt | zero_flag_i;

	// ****************************************
	// reference terms, built from the pins only
	// ****************************************
	// kept apart from the base test unit so a slip there shows up here
	wire logic [BASE_N-1:0] ref_tests;
	assign ref_tests[BT_OVERFLOW] = overflow_flag_i;
	assign ref_tests[BT_CARRY]    = carry_flag_i;
	assign ref_tests[BT_ZERO]     = zero_flag_i;
	assign ref_tests[BT_CARRY_ZR] = carry_flag_i | zero_flag_i;
	assign ref_tests[BT_SIGN]     = sign_flag_i;
	assign ref_tests[BT_PARITY]   = parity_flag_i;
	assign ref_tests[BT_LESS]     = ref_lt;
	assign ref_tests[BT_LESS_EQ]  = ref_le;

	AST_OVERFLOW_SET: assert property (
		(subcode_i == SC_OVERFLOW) |-> (cond_true_o == overflow_flag_i))
		else $error("overflow test wrong");
	AST_OVERFLOW_CLR: assert property (
		(subcode_i == SC_NO_OVERFLOW) |-> (cond_true_o == !overflow_flag_i))
		else $error("no-overflow test wrong");
	AST_ZERO_SET: assert property (
		(subcode_i == SC_EQUAL) |-> (cond_true_o == zero_flag_i))
		else $error("equal test wrong");
	AST_ZERO_CLR: assert property (
		(subcode_i == SC_NOT_EQUAL) |-> (cond_true_o == !zero_flag_i))
		else $error("not-equal test wrong");
	AST_SIGN_SET: assert property (
		(subcode_i == SC_SIGN) |-> (cond_true_o == sign_flag_i))
		else $error("sign test wrong");
	AST_SIGN_CLR: assert property (
		(subcode_i == SC_NO_SIGN) |-> (cond_true_o == !sign_flag_i))
		else $error("no-sign test wrong");
	AST_PARITY_SET: assert property (
		(subcode_i == SC_PARITY) |-> (cond_true_o == parity_flag_i))
		else $error("parity test wrong");
	AST_PARITY_CLR: assert property (
		(subcode_i == SC_NO_PARITY) |-> (cond_true_o == !parity_flag_i))
		else $error("no-parity test wrong");

	AST_BELOW: assert property (
		(subcode_i == SC_BELOW) |-> (cond_true_o == carry_flag_i))
		else $error("below test wrong");
	AST_ABOVE_EQ: assert property (
		(subcode_i == SC_ABOVE_EQ) |-> (cond_true_o == !carry_flag_i))
		else $error("above-or-equal test wrong");

	AST_BELOW_EQ: assert property (
		(subcode_i == SC_BELOW_EQ)
		|-> (cond_true_o == (carry_flag_i | zero_flag_i)))
		else $error("below-or-equal test wrong");
	AST_ABOVE: assert property (
		(subcode_i == SC_ABOVE)
		|-> (cond_true_o == !(carry_flag_i | zero_flag_i)))
		else $error("above test wrong");

	AST_LESS: assert property (
		(subcode_i == SC_LESS) |-> (cond_true_o == ref_lt))
		else $error("less test wrong");
	AST_GREATER_EQ: assert property (
		(subcode_i == SC_GREATER_EQ) |-> (cond_true_o == !ref_lt))
		else $error("greater-or-equal test wrong");

	AST_LESS_EQ: assert property (
		(subcode_i == SC_LESS_EQ) |-> (cond_true_o == ref_le))
		else $error("less-or-equal test wrong");
	AST_GREATER: assert property (
		(subcode_i == SC_GREATER) |-> (cond_true_o == !ref_le))
		else $error("greater test wrong");

	// unsigned tests ignore the signed flags entirely
	AST_UNSIGNED_SRC: assert property (
		((subcode_i == SC_ABOVE) || (subcode_i == SC_BELOW))
		&& $stable(subcode_i) && $stable(carry_flag_i)
		&& $stable(zero_flag_i) |-> $stable(cond_true_o))
		else $error("unsigned test moved without its flags");

	// signed tests ignore carry entirely
	AST_SIGNED_SRC: assert property (
		((subcode_i == SC_LESS) || (subcode_i == SC_GREATER))
		&& $stable(subcode_i) && $stable(sign_flag_i)
		&& $stable(overflow_flag_i) && $stable(zero_flag_i)
		|-> $stable(cond_true_o))
		else $error("signed test moved without its flags");

	// each pair is a test and its exact complement
	AST_PAIR_COMPL: assert property (
		$stable(pair_idx) && $stable(fl.base_tests)
		&& $changed(negated) |-> $changed(cond_true_o))
		else $error("pair members are not complements");

	AST_RANGE: assert property (
		cond_true_o == (ref_tests[subcode_i[SUBCODE_W-1:IDX_LSB]] ^ subcode_i[POL_BIT]))
		else $error("subcode not decoded over full range");

	// registered path: request, then answer one edge later
	sequence seq_set_req;
		!rst_i && valid_i && (family_i == FAM_SET);
	endsequence

	sequence seq_set_ans(logic t);
		result_valid_o && (set_byte_o == (t ? SET_TRUE : SET_FALSE));
	endsequence

	AST_SET_BYTE: assert property (
		seq_set_req |=> seq_set_ans($past(cond_true)))
		else $error("set-byte result wrong");

	AST_JUMP_SAME: assert property (
		valid_i && (family_i == FAM_JUMP) |-> (jump_taken_o == cond_true_o))
		else $error("jump disagrees with shared evaluation");

	AST_MOVE_SAME: assert property (
		valid_i && ((family_i == FAM_MOVE) || (family_i == FAM_FMOVE))
		|-> (move_en_o == cond_true_o) && !jump_taken_o)
		else $error("move disagrees with shared evaluation");

	AST_SAME_CYCLE: assert property (
		!rst_i && $changed(cond_true) |-> $changed(cond_true_o)
		##1 (cond_ff_o == $past(cond_true_o)))
		else $error("result not same-cycle");

	AST_IDLE_QUIET: assert property (
		!valid_i |-> !move_en_o && !jump_taken_o ##1 !result_valid_o)
		else $error("answer without request");

	// ****************************************
	// registered path and steering checks
	// ****************************************
	// reset is watched with the default disable lifted
	sequence seq_in_reset;
		rst_i;
	endsequence

	sequence seq_cleared;
		!result_valid_o && !cond_ff_o && (set_byte_o == SET_FALSE);
	endsequence

	AST_RESET_CLEAR: assert property (
		disable iff (1'b0) seq_in_reset |=> seq_cleared)
		else $error("registered outputs not cleared by reset");

	AST_RV_FOLLOWS: assert property (
		!rst_i |=> (result_valid_o == $past(valid_i)))
		else $error("result valid does not follow request");

	AST_COND_FF: assert property (
		!rst_i |=> (cond_ff_o == $past(cond_true_o)))
		else $error("registered condition does not follow");

	// the set byte is a holding register, not a pulse
	sequence seq_no_set_req;
		!rst_i && !(valid_i && (family_i == FAM_SET));
	endsequence

	AST_SET_HOLD: assert property (
		seq_no_set_req |=> $stable(set_byte_o))
		else $error("set byte moved without a set request");

	AST_SET_NO_STEER: assert property (
		(family_i == FAM_SET) |-> !move_en_o && !jump_taken_o)
		else $error("set-byte request steered to move or jump");

	AST_JUMP_ONLY: assert property (
		(family_i != FAM_JUMP) |-> !jump_taken_o)
		else $error("jump taken outside the jump family");

	AST_VALID_GATE: assert property (
		valid_i && cond_true_o && (family_i != FAM_SET)
		|-> move_en_o || jump_taken_o)
		else $error("true condition not passed on");

	// the family only routes; the test itself never sees it
	AST_FAMILY_BLIND: assert property (
		$stable(subcode_i) && $changed(family_i)
		&& $stable({carry_flag_i, overflow_flag_i, sign_flag_i, zero_flag_i, parity_flag_i})
		|-> $stable(cond_true_o))
		else $error("family input altered the condition");

endmodule : ccev_top

// >>> test/ccev_exec_model.sv
// condition code evaluator bench: execute-side consumer of the answers
// assumes: answers arrive on core_clk_i; tallies clear while rst_i is high

`timescale 1ns/1ps

module ccev_exec_model
	import ccev_pkg::*;
(
	// clock and reset
	input  wire logic        core_clk_i,
	input  wire logic        rst_i,
	// answers from the evaluator
	input  wire logic        move_en_i,
	input  wire logic        jump_taken_i,
	input  wire logic        result_valid_i,
	input  wire logic [7:0]  set_byte_i,
	// tallies of acted-on answers
	output logic      [15:0] move_cnt_o,
	output logic      [15:0] jump_cnt_o,
	output logic      [15:0] set_cnt_o
);
	// ****************************************
	// tallies
	// ****************************************
	// sampled at the edge, so a same-cycle answer must be settled by then
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			move_cnt_o <= 16'h0000;
			jump_cnt_o <= 16'h0000;
			set_cnt_o  <= 16'h0000;
		end else begin
			move_cnt_o <= move_cnt_o + 16'(move_en_i);
			jump_cnt_o <= jump_cnt_o + 16'(jump_taken_i);
			set_cnt_o  <= set_cnt_o + 16'(result_valid_i && set_byte_i == SET_TRUE);
		end
	end
endmodule : ccev_exec_model

// >>> test/condition_code_evaluator_tb.sv
// condition code evaluator bench: table sweep of all subcodes and flags
// assumes: inputs change only by non-blocking writes at the rising edge

`timescale 1ns/1ps

module condition_code_evaluator_tb
	import ccev_pkg::*;
;
	typedef struct packed {
		logic       v;
		logic [1:0] fam;
		logic [3:0] sc;
		logic [4:0] fl;
		logic       c;
	} ccev_row_t;

	logic        clk;
	logic        rst;
	logic        valid;
	logic [1:0]  family;
	logic [3:0]  subcode;
	logic [4:0]  flags;
	logic        cond_true;
	logic        move_en;
	logic        jump_taken;
	logic        cond_ff;
	logic        result_valid;
	logic [7:0]  set_byte;
	logic [15:0] move_cnt;
	logic [15:0] jump_cnt;
	logic [15:0] set_cnt;
	int          fails;
	int          n_checks;
	int          cm;
	int          cj;
	int          cs;
	logic        pm;
	logic        pj;
	logic        ps;
	logic        last_r;
	logic        e_rv;
	logic        e_cff;
	logic [7:0]  e_set;
	ccev_row_t   rows [512];

	// ****************************************
	// design and partner
	// ****************************************
	ccev_top i_ccev_top (
		.core_clk_i      (clk),
		.rst_i           (rst),
		.valid_i         (valid),
		.family_i        (family),
		.subcode_i       (subcode),
		.carry_flag_i    (flags[4]),
		.overflow_flag_i (flags[3]),
		.sign_flag_i     (flags[2]),
		.zero_flag_i     (flags[1]),
		.parity_flag_i   (flags[0]),
		.cond_true_o     (cond_true),
		.move_en_o       (move_en),
		.jump_taken_o    (jump_taken),
		.cond_ff_o       (cond_ff),
		.result_valid_o  (result_valid),
		.set_byte_o      (set_byte)
	);

	ccev_exec_model i_ccev_exec_model (
		.core_clk_i     (clk),
		.rst_i          (rst),
		.move_en_i      (move_en),
		.jump_taken_i   (jump_taken),
		.result_valid_i (result_valid),
		.set_byte_i     (set_byte),
		.move_cnt_o     (move_cnt),
		.jump_cnt_o     (jump_cnt),
		.set_cnt_o      (set_cnt)
	);

	// ****************************************
	// reference and helpers
	// ****************************************
	function automatic logic ref_cond(input logic [3:0] sc, input logic [4:0] f);
		logic c, o, s, z, p, t;
		{c, o, s, z, p} = f;
		case (sc[3:1])
			3'h0: t = o;
			3'h1: t = c;
			3'h2: t = z;
			3'h3: t = c | z;
			3'h4: t = s;
			3'h5: t = p;
			3'h6: t = s ^ o;
			default: t = (s ^ o) | z;
		endcase
		return t ^ sc[0];
	endfunction : ref_cond

	function automatic ccev_row_t mk(input logic v, input logic [1:0] fam,
			input logic [3:0] sc, input logic [4:0] fl);
		return {v, fam, sc, fl, ref_cond(sc, fl)};
	endfunction : mk

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic end_sim;
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : end_sim

	// one cycle: drive at the edge, check after it settles
	task automatic step(input logic r, input ccev_row_t w);
		@(posedge clk);
		rst <= r;
		valid <= w.v;
		family <= w.fam;
		subcode <= w.sc;
		flags <= w.fl;
		#1;
		if (last_r) begin
			cm = 0;
			cj = 0;
			cs = 0;
		end else begin
			cm += int'(pm);
			cj += int'(pj);
			cs += int'(ps);
		end
		check(16'(cond_true), 16'(w.c));
		check(16'(move_en), 16'(w.v & ~w.fam[1] & w.c));
		check(16'(jump_taken), 16'(w.v & (w.fam == 2'h2) & w.c));
		check(16'(cond_ff), 16'(e_cff));
		check(16'(result_valid), 16'(e_rv));
		check(16'(set_byte), 16'(e_set));
		check(move_cnt, 16'(cm));
		check(jump_cnt, 16'(cj));
		check(set_cnt, 16'(cs));
		ps = e_rv & (e_set == SET_TRUE);
		pm = w.v & ~w.fam[1] & w.c;
		pj = w.v & (w.fam == 2'h2) & w.c;
		last_r = r;
		e_rv = ~r & w.v;
		e_cff = ~r & w.c;
		if (r)
			e_set = SET_FALSE;
		else if (w.v && w.fam == 2'h3)
			e_set = w.c ? SET_TRUE : SET_FALSE;
	endtask : step

	// ****************************************
	// clock, watchdog, sequence
	// ****************************************
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// no wait should come near this; a hang counts as a mismatch
	initial begin
		#100000;
		fails++;
		end_sim();
	end

	initial begin
		{rst, valid, family, subcode, flags} = {1'b1, 1'b0, 2'h0, 4'h0, 5'h00};
		{fails, n_checks, cm, cj, cs} = '0;
		{pm, pj, ps, last_r, e_rv, e_cff, e_set} = {6'h04, SET_FALSE};
		for (int k = 0; k < 8; k++)
			step(1'b1, mk(1'b1, 2'h3, SC_EQUAL, 5'h02));
		$display("test reset done");
		for (int i = 0; i < 512; i++)
			rows[i] = mk((i % 7) != 0, 2'(i >> 2) ^ 2'(i >> 5), 4'(i >> 5), 5'(i));
		foreach (rows[i])
			step(1'b0, rows[i]);
		$display("test table done");
		// set byte holds across idle and other families, then back to back
		step(1'b0, mk(1'b1, 2'h3, SC_EQUAL, 5'h02));
		step(1'b0, mk(1'b1, 2'h1, SC_EQUAL, 5'h02));
		step(1'b0, mk(1'b0, 2'h3, SC_EQUAL, 5'h00));
		step(1'b0, mk(1'b1, 2'h2, SC_NOT_EQUAL, 5'h00));
		step(1'b0, mk(1'b1, 2'h3, SC_GREATER, 5'h02));
		step(1'b0, mk(1'b1, 2'h3, SC_LESS, 5'h04));
		$display("test set byte hold done");
		// second reset in mid-run, answers still follow inputs meanwhile
		step(1'b1, mk(1'b1, 2'h0, SC_BELOW, 5'h10));
		step(1'b0, mk(1'b1, 2'h1, SC_ABOVE, 5'h00));
		step(1'b0, mk(1'b0, 2'h0, SC_OVERFLOW, 5'h00));
		step(1'b0, mk(1'b0, 2'h0, SC_OVERFLOW, 5'h00));
		$display("test mid-run reset done");
		end_sim();
	end
endmodule : condition_code_evaluator_tb
